//--- mgd_pkg.sv
// Overview of operation
// - at most 3 bytes, 8 cycles unwaited
// - wait states stretch external accesses, never SRAM
// - each wait state adds the per-opcode increment
// - indirect operand names SRAM pointer pair
// - low address byte from pointer location
// - 0x10 register copy, 3 bytes, 5+3/ws
// - 0x11 register to indirect, 5+3/ws
// - 0x12 indirect to register, 6+3/ws
// - 0x13 immediate to register, 4+3/ws
// - 0x14 code space read, 7+4/ws
// - 0x15 code space write, 8+4/ws
// - 0x16 data space read, 7+4/ws
// - 0x17 data space write, 8+4/ws
// - code read strobe may stay low across fetches
// - decoder knows all 52 opcodes by group
// - high address byte from pointer plus one
// - separate code and data read strobes
// - separate code and data write strobes
`default_nettype none
package mgd_pkg;
    // move group opcodes
    localparam logic [7:0] OPC_MOV_RR = 8'h10;
    localparam logic [7:0] OPC_MOV_RI = 8'h11;
    localparam logic [7:0] OPC_MOV_IR = 8'h12;
    localparam logic [7:0] OPC_MOV_IMM = 8'h13;
    localparam logic [7:0] OPC_MOVC_RD = 8'h14;
    localparam logic [7:0] OPC_MOVC_WR = 8'h15;
    localparam logic [7:0] OPC_MOVX_RD = 8'h16;
    localparam logic [7:0] OPC_MOVX_WR = 8'h17;
    // reset values and widths
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] CYC_RST = 5'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam int SRAM_DEPTH = 256;

    typedef struct packed {
        logic valid;
        logic move;
        logic [1:0] len;
        logic [3:0] base;
        logic [2:0] inc;
    } mgd_dec_t;

    // length and timing per opcode; unknown codes cost one byte, 2+1/ws
    function automatic mgd_dec_t mgd_decode(input logic [7:0] op);
        mgd_dec_t d;
        d = '{valid: 1'b0, move: 1'b0, len: 2'h1, base: 4'h2, inc: 3'h1};
        if (op <= 8'h05) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h1, base: 4'h2, inc: 3'h1};
        end else if (op >= OPC_MOV_RR && op <= OPC_MOVX_WR) begin
            d.valid = 1'b1;
            d.move = 1'b1;
            d.len = 2'h3;
            unique case (op)
                OPC_MOV_RR, OPC_MOV_RI: begin d.base = 4'h5; d.inc = 3'h3; end
                OPC_MOV_IR: begin d.base = 4'h6; d.inc = 3'h3; end
                OPC_MOV_IMM: begin d.base = 4'h4; d.inc = 3'h3; end
                OPC_MOVC_RD, OPC_MOVX_RD: begin d.base = 4'h7; d.inc = 3'h4; end
                default: begin d.base = 4'h8; d.inc = 3'h4; end
            endcase
        end else if (op >= 8'h20 && op <= 8'h27) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h3, base: 4'h3, inc: 3'h3};
        end else if (op == 8'h28 || op == 8'h29) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h1, base: 4'h2, inc: 3'h1};
        end else if (op == 8'h2A) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h2, base: 4'h4, inc: 3'h2};
        end else if (op >= 8'h30 && op <= 8'h36) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h2, base: 4'h5, inc: 3'h2};
        end else if (op >= 8'h40 && op <= 8'h48) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h3, base: 4'h6, inc: 3'h3};
        end else if (op == 8'h49 || op == 8'h4A) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h2, base: 4'h5, inc: 3'h2};
        end else if (op >= 8'h50 && op <= 8'h58) begin
            d = '{valid: 1'b1, move: 1'b0, len: 2'h3, base: 4'h5, inc: 3'h3};
        end
        return d;
    endfunction : mgd_decode
endpackage : mgd_pkg
`default_nettype wire

//--- mgd_regfile.sv
`timescale 1ns/1ns
`default_nettype none
module mgd_regfile
    import mgd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // two asynchronous read ports
    input wire logic [7:0] ra,
    input wire logic [7:0] rb,
    output logic [7:0] rd_a,
    output logic [7:0] rd_b,
    // one write port
    input wire logic we,
    input wire logic [7:0] wa,
    input wire logic [7:0] wd
);
    logic [7:0] mem_r [SRAM_DEPTH];

    // one flip-flop byte per entry; never stalled by wait states
    genvar i;
    generate
        for (i = 0; i < SRAM_DEPTH; i++) begin : g_ent
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[i] <= BYTE_RST;
                end else if (we && wa == 8'(i)) begin
                    mem_r[i] <= wd;
                end
            end
        end
    endgenerate

    assign rd_a = mem_r[ra];
    assign rd_b = mem_r[rb];
endmodule : mgd_regfile
`default_nettype wire

//--- mgd_core.sv
`timescale 1ns/1ns
`default_nettype none
module mgd_core
    import mgd_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // wait state strap pins
    input wire logic [1:0] WAIT_STATES,
    // external memory bus
    output logic [15:0] ADDR,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic CODE_READ_STROBE_N,
    output logic DATA_READ_STROBE_N,
    output logic CODE_WRITE_STROBE_N,
    output logic DATA_WRITE_STROBE_N,
    // status
    output logic INSN_DONE,
    output logic BAD_OPCODE,
    output logic FLAG_C,
    output logic FLAG_S,
    output logic FLAG_Z
);
    typedef enum logic [2:0] {ST_FETCH, ST_PTR, ST_SRAM, ST_SETUP, ST_EXT, ST_HOLD, ST_PAD} mgd_state_t;

    mgd_state_t state_r;
    logic [1:0] ws_s1_r, ws_s2_r, ws_r;
    logic [4:0] cyc_r;
    logic [1:0] slot_r, idx_r;
    logic [15:0] pc_r, tgt_r;
    logic [7:0] op_r, opa_r, opb_r, wdata_r;
    logic [2:0] flags_r;
    logic [7:0] cur_op, ptr_sel, ra, rb, rd_a, rd_b, wa, wd;
    logic we, slot_end, last_cyc, byte_last, is_ext_wr;
    logic [4:0] total;
    mgd_dec_t dec;

    // strap pins come from outside, so two flops before use
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ws_s1_r <= 2'h0;
            ws_s2_r <= 2'h0;
        end else begin
            ws_s1_r <= WAIT_STATES;
            ws_s2_r <= ws_s1_r;
        end
    end

    // opcode seen on the bus during its own slot, else the captured one
    assign cur_op = (state_r == ST_FETCH && idx_r == 2'h0) ? DATA_IN : op_r;
    assign dec = mgd_decode(cur_op);
    assign total = 5'(dec.base) + 5'(ws_r) * 5'(dec.inc);
    assign slot_end = (slot_r == ws_r);
    assign byte_last = (5'(idx_r) + 5'h01 == 5'(dec.len));
    // the opcode slot never ends an instruction, so bus noise there is harmless
    assign last_cyc = (cyc_r != CYC_RST) && !(state_r == ST_FETCH && idx_r == 2'h0)
                      && (cyc_r == total - 5'h01);
    assign is_ext_wr = (op_r == OPC_MOVC_WR) || (op_r == OPC_MOVX_WR);

    // sequencer: the cycle budget from the table ends every instruction
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_FETCH;
            cyc_r <= CYC_RST;
            slot_r <= 2'h0;
            idx_r <= 2'h0;
            ws_r <= 2'h0;
        end else if (last_cyc) begin
            state_r <= ST_FETCH;
            cyc_r <= CYC_RST;
            slot_r <= 2'h0;
            idx_r <= 2'h0;
            ws_r <= ws_s2_r; // new wait count only between instructions
        end else begin
            cyc_r <= cyc_r + 5'h01;
            unique case (state_r)
                ST_FETCH: begin
                    if (!slot_end) begin
                        slot_r <= slot_r + 2'h1;
                    end else begin
                        slot_r <= 2'h0;
                        if (byte_last) begin
                            idx_r <= 2'h0;
                            if (!dec.move) begin
                                state_r <= ST_PAD;
                            end else if (op_r == OPC_MOV_RR || op_r == OPC_MOV_IMM) begin
                                state_r <= ST_SRAM;
                            end else begin
                                state_r <= ST_PTR;
                            end
                        end else begin
                            idx_r <= idx_r + 2'h1;
                        end
                    end
                end
                ST_PTR: begin
                    if (op_r == OPC_MOV_RI || op_r == OPC_MOV_IR) begin
                        state_r <= ST_SRAM;
                    end else if (is_ext_wr) begin
                        state_r <= ST_SETUP;
                    end else begin
                        state_r <= ST_EXT;
                    end
                end
                ST_SRAM: state_r <= ST_PAD;
                ST_SETUP: state_r <= ST_EXT;
                ST_EXT: begin
                    if (!slot_end) begin
                        slot_r <= slot_r + 2'h1;
                    end else begin
                        slot_r <= 2'h0;
                        state_r <= is_ext_wr ? ST_HOLD : ST_PAD;
                    end
                end
                ST_HOLD: state_r <= ST_PAD;
                ST_PAD: state_r <= ST_PAD;
            endcase
        end
    end

    // program counter and instruction bytes, one per fetch slot
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_r <= PC_RST;
            op_r <= BYTE_RST;
            opa_r <= BYTE_RST;
            opb_r <= BYTE_RST;
        end else if (state_r == ST_FETCH && slot_end) begin
            pc_r <= pc_r + 16'h0001;
            unique case (idx_r)
                2'h0: op_r <= DATA_IN;
                2'h1: opa_r <= DATA_IN;
                default: opb_r <= DATA_IN;
            endcase
        end
    end

    // pointer operand: first for destination forms, second for source forms
    assign ptr_sel = (op_r == OPC_MOV_RI || is_ext_wr) ? opa_r : opb_r;
    assign ra = (state_r == ST_PTR) ? ptr_sel
              : (state_r == ST_SRAM && op_r == OPC_MOV_IR) ? tgt_r[7:0] : opb_r;
    assign rb = (op_r == OPC_MOV_RI) ? opb_r : ptr_sel + PTR_STEP;

    // target address and write data captured from the register file
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tgt_r <= PC_RST;
            wdata_r <= BYTE_RST;
        end else if (state_r == ST_PTR) begin
            if (op_r == OPC_MOV_RI) begin
                tgt_r <= {BYTE_RST, rd_a};
                wdata_r <= rd_b;
            end else begin
                tgt_r <= {rd_b, rd_a};
            end
        end else if (state_r == ST_SETUP) begin
            wdata_r <= rd_a; // source byte held for the whole write
        end
    end

    // register file writes for every move that lands in SRAM
    always_comb begin
        we = 1'b0;
        wa = opa_r;
        wd = rd_a;
        if (state_r == ST_SRAM) begin
            we = 1'b1;
            unique case (op_r)
                OPC_MOV_RI: begin wa = tgt_r[7:0]; wd = wdata_r; end
                OPC_MOV_IMM: wd = opb_r;
                default: wd = rd_a;
            endcase
        end else if (state_r == ST_EXT && slot_end && !is_ext_wr) begin
            we = 1'b1;
            wd = DATA_IN;
        end
    end

    mgd_regfile u_regfile (
        .clk(CLK),
        .rst_n(RST_N),
        .ra(ra),
        .rb(rb),
        .rd_a(rd_a),
        .rd_b(rd_b),
        .we(we),
        .wa(wa),
        .wd(wd)
    );

    // condition flags are never written by any group, so moves never touch them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_r <= 3'h0;
        end else begin
            flags_r <= flags_r;
        end
    end

    // bus pins: the address source is a flop in every state
    assign ADDR = (state_r == ST_FETCH) ? pc_r : tgt_r;
    assign DATA_OUT = wdata_r;
    assign DATA_OE = is_ext_wr && (state_r == ST_SETUP || state_r == ST_EXT || state_r == ST_HOLD);
    // code strobe stays low through all bytes of a fetch run
    assign CODE_READ_STROBE_N = !(state_r == ST_FETCH
                                  || (state_r == ST_EXT && op_r == OPC_MOVC_RD));
    assign DATA_READ_STROBE_N = !(state_r == ST_EXT && op_r == OPC_MOVX_RD);
    assign CODE_WRITE_STROBE_N = !(state_r == ST_EXT && op_r == OPC_MOVC_WR);
    assign DATA_WRITE_STROBE_N = !(state_r == ST_EXT && op_r == OPC_MOVX_WR);
    assign INSN_DONE = last_cyc;
    assign BAD_OPCODE = last_cyc && !dec.valid;
    assign FLAG_C = flags_r[0];
    assign FLAG_S = flags_r[1];
    assign FLAG_Z = flags_r[2];

    // no instruction overruns eight cycles without wait states
    cycle_limit_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (ws_r == 2'h0) |-> (cyc_r <= 5'h07))
        else $error("instruction exceeded eight cycles");

    // SRAM access is always one cycle whatever the wait count
    sram_nowait_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_SRAM) |=> (state_r != ST_SRAM))
        else $error("SRAM access stretched");

    // register copy ends at its exact budget
    mov_rr_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r == OPC_MOV_RR) |-> (cyc_r == 5'h04 + 5'(ws_r) * 5'h03))
        else $error("register copy length wrong");

    // immediate load ends at its exact budget and writes the operand
    mov_imm_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_SRAM && op_r == OPC_MOV_IMM)
        |-> (we && wa == opa_r && wd == opb_r && cyc_r == 5'h03 + 5'(ws_r) * 5'h03))
        else $error("immediate load wrong");

    // write moves to code space run to eight cycles plus four per wait
    movc_wr_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r == OPC_MOVC_WR) |-> (cyc_r == 5'h07 + 5'(ws_r) * 5'h04))
        else $error("code write length wrong");

    // pointer pair forms the target address
    ptr_pair_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_PTR && op_r == OPC_MOVX_RD)
        |=> (tgt_r == {$past(rd_b), $past(rd_a)}))
        else $error("pointer pair not used for address");

    // code strobe does not rise between bytes of one fetch
    fetch_run_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_FETCH && slot_end && !byte_last && !last_cyc) |=> !CODE_READ_STROBE_N)
        else $error("code strobe broke inside fetch");

    // data read strobe never overlaps the code strobe and matches the opcode
    read_strobes_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !DATA_READ_STROBE_N |-> (CODE_READ_STROBE_N && op_r == OPC_MOVX_RD))
        else $error("data read strobe misused");

    // write strobe rises with address and data still held
    write_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        ($rose(CODE_WRITE_STROBE_N) || $rose(DATA_WRITE_STROBE_N))
        |-> (DATA_OE && $stable(ADDR) && $stable(DATA_OUT)))
        else $error("write released without hold");

    // flags stay put across moves
    flags_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (op_r >= OPC_MOV_RR && op_r <= OPC_MOVX_WR) |=> $stable({FLAG_C, FLAG_S, FLAG_Z}))
        else $error("move changed flags");

    // indirect register store ends at its exact budget
    mov_ri_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r == OPC_MOV_RI) |-> (cyc_r == 5'h04 + 5'(ws_r) * 5'h03))
        else $error("indirect store length wrong");

    // indirect load pays one more cycle for the pointer read
    mov_ir_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r == OPC_MOV_IR) |-> (cyc_r == 5'h05 + 5'(ws_r) * 5'h03))
        else $error("indirect load length wrong");

    // code and data reads both run seven cycles plus four per wait
    ext_read_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && (op_r == OPC_MOVC_RD || op_r == OPC_MOVX_RD)) |-> (cyc_r == 5'h06 + 5'(ws_r) * 5'h04))
        else $error("external read length wrong");

    // data space write matches the code space write budget
    movx_wr_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r == OPC_MOVX_WR) |-> (cyc_r == 5'h07 + 5'(ws_r) * 5'h04))
        else $error("data write length wrong");

    // slow code memory sees one steady address through every wait state
    fetch_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_FETCH && !slot_end) |=> ($stable(ADDR) && !CODE_READ_STROBE_N))
        else $error("fetch address moved inside a slot");

    // a write strobe is only low while the data bus is driven
    write_oe_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!CODE_WRITE_STROBE_N || !DATA_WRITE_STROBE_N) |-> DATA_OE)
        else $error("write strobe without data drive");

    // register store target is the byte at the pointer, high byte unused
    ri_target_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_r == ST_PTR && op_r == OPC_MOV_RI) |=> (tgt_r[7:0] == $past(rd_a) && tgt_r[15:8] == BYTE_RST))
        else $error("store target not from pointer");

    // every move opcode is known to the decoder
    move_known_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (INSN_DONE && op_r >= OPC_MOV_RR && op_r <= OPC_MOVX_WR) |-> !BAD_OPCODE)
        else $error("move opcode flagged as unknown");
endmodule : mgd_core
`default_nettype wire

//--- mgd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mgd_mem_model (
    // clock
    input wire logic clk,
    // bus driven by the core
    input wire logic [15:0] addr,
    input wire logic [7:0] data_out,
    input wire logic code_rd_n,
    input wire logic data_rd_n,
    input wire logic code_wr_n,
    input wire logic data_wr_n,
    // bus driven by the memories
    output logic [7:0] data_in
);
    logic [7:0] code_mem [0:65535];
    logic [7:0] data_mem [0:65535];
    logic [7:0] idle_pat_r = 8'hA5;

    // zero fill reads back as a stream of no-operation opcodes
    task automatic clear();
        foreach (code_mem[i]) begin
            code_mem[i] = 8'h00;
            data_mem[i] = 8'h00;
        end
    endtask : clear

    // a released bus wanders every cycle, so a stale byte never matches by luck
    always @(posedge clk) begin
        idle_pat_r <= ~idle_pat_r;
    end

    // no handshake: the byte appears within the cycle, slow parts lean on wait states
    always_comb begin
        if (!code_rd_n) begin
            data_in = code_mem[addr];
        end else if (!data_rd_n) begin
            data_in = data_mem[addr];
        end else begin
            data_in = idle_pat_r;
        end
    end

    // writes land at every edge under the strobe; wait states just rewrite the byte
    always @(posedge clk) begin
        if (!code_wr_n) code_mem[addr] <= data_out;
        if (!data_wr_n) data_mem[addr] <= data_out;
    end
endmodule : mgd_mem_model
`default_nettype wire

//--- mgd_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mgd_core_bench;
    import mgd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] wait_states = 2'h0;
    logic [15:0] addr, prev_addr;
    logic [7:0] data_in, data_out, prev_dout;
    logic data_oe, crd_n, drd_n, cwr_n, dwr_n, insn_done, bad_opcode, flag_c, flag_s, flag_z;
    logic ext_low, prev_low, prev_crd;
    int mismatches = 0;
    int n_tests = 0;
    int cur_ws = 0;
    int run_len = 0;
    int seq_fetch = 0;

    mgd_core dut (
        .CLK(clk), .RST_N(rst_n), .WAIT_STATES(wait_states), .ADDR(addr), .DATA_IN(data_in),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .CODE_READ_STROBE_N(crd_n), .DATA_READ_STROBE_N(drd_n),
        .CODE_WRITE_STROBE_N(cwr_n), .DATA_WRITE_STROBE_N(dwr_n), .INSN_DONE(insn_done),
        .BAD_OPCODE(bad_opcode), .FLAG_C(flag_c), .FLAG_S(flag_s), .FLAG_Z(flag_z)
    );
    mgd_mem_model mem (
        .clk(clk), .addr(addr), .data_out(data_out), .code_rd_n(crd_n), .data_rd_n(drd_n),
        .code_wr_n(cwr_n), .data_wr_n(dwr_n), .data_in(data_in)
    );
    assign ext_low = !drd_n || !cwr_n || !dwr_n;

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // reset, load the program, release after two cycles
    task automatic start(input logic [1:0] ws, input logic [7:0] prog [$]);
        @(posedge clk);
        rst_n <= 1'b0;
        wait_states <= ws;
        cur_ws = ws;
        mem.clear();
        foreach (prog[i]) mem.code_mem[i] = prog[i];
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : start

    // cycles up to and including the next completion pulse
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (insn_done !== 1'b1 && n < 64);
    endtask : wait_done

    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(addr, 16'h0000);
        check({crd_n, drd_n, cwr_n, dwr_n, data_oe, insn_done}, 6'b011100);
        check({flag_c, flag_s, flag_z}, 3'b000);
    endtask : t_reset

    // every move, one of each other timing class and one unknown code, lengths drive the fetch
    task automatic t_timing(input logic [1:0] ws);
        logic [7:0] ops [17] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h30, 8'hFF,
                                 8'h05, 8'h20, 8'h28, 8'h2A, 8'h40, 8'h49, 8'h50};
        int base [17] = '{5, 5, 6, 4, 7, 8, 7, 8, 5, 2, 2, 3, 2, 4, 6, 5, 5};
        int inc [17] = '{3, 3, 3, 3, 4, 4, 4, 4, 2, 1, 1, 3, 1, 2, 3, 2, 3};
        int len [17] = '{3, 3, 3, 3, 3, 3, 3, 3, 2, 1, 1, 3, 1, 2, 3, 2, 3};
        logic [7:0] prog [$];
        int n;
        // two short no-ops first: the strap count reaches the sequencer only after both
        prog = '{8'h00, 8'h00};
        for (int i = 0; i < 17; i++) begin
            prog.push_back(ops[i]);
            if (len[i] > 1) prog.push_back(8'h02);
            if (len[i] > 2) prog.push_back(8'h00);
        end
        start(ws, prog);
        repeat (2) wait_done(n);
        for (int i = 0; i < 17; i++) begin
            wait_done(n);
            check(n, base[i] + inc[i] * ws);
            check(bad_opcode, ops[i] == 8'hFF);
            if (ws == 2'h0) check(n <= 8 && len[i] <= 3, 1'b1);
        end
        check({flag_c, flag_s, flag_z}, 3'b000);
    endtask : t_timing

    // pointers at even registers, distinct low bytes and a high byte from pointer plus one
    task automatic t_indirect();
        logic [7:0] prog [$];
        int n;
        prog = '{8'h13, 8'h10, 8'h34, 8'h13, 8'h11, 8'hA2, 8'h13, 8'h12, 8'h00, 8'h13, 8'h13, 8'hA3,
                 8'h13, 8'h14, 8'h01, 8'h13, 8'h15, 8'hA3, 8'h13, 8'h16, 8'h02, 8'h13, 8'h17, 8'hA3,
                 8'h13, 8'h40, 8'h50, 8'h16, 8'h30, 8'h10, 8'h14, 8'h31, 8'h10, 8'h10, 8'h32, 8'h30,
                 8'h11, 8'h40, 8'h31, 8'h12, 8'h34, 8'h40, 8'h17, 8'h12, 8'h32, 8'h17, 8'h14, 8'h34,
                 8'h15, 8'h16, 8'h30};
        start(2'h1, prog);
        mem.data_mem[16'hA234] = 8'h77;
        mem.code_mem[16'hA234] = 8'h99;
        for (int i = 0; i < 17; i++) wait_done(n);
        check(mem.data_mem[16'hA300], 8'h77);
        check(mem.data_mem[16'hA301], 8'h99);
        check(mem.code_mem[16'hA302], 8'h77);
        check({mem.code_mem[16'hA300], mem.data_mem[16'hA302]}, 16'h0000);
        check(seq_fetch > 0, 1'b1);
        check({flag_c, flag_s, flag_z}, 3'b000);
    endtask : t_indirect

    // mid-cycle watch of the external strobes; data read and write strobe width follows the wait states
    always @(negedge clk) begin
        if (!rst_n) begin
            run_len = 0;
            prev_low = 1'b0;
        end else begin
            check($countones({~crd_n, ~drd_n, ~cwr_n, ~dwr_n}) <= 1, 1'b1);
            if (ext_low) begin
                if (prev_low) check(addr, prev_addr);
                if (!cwr_n || !dwr_n) check(data_oe, 1'b1);
                if ((!cwr_n || !dwr_n) && prev_low) check(data_out, prev_dout);
                run_len++;
            end else if (prev_low) begin
                check(run_len, 1 + cur_ws);
                run_len = 0;
            end
            if (!crd_n && prev_crd && addr == prev_addr + 16'h1) seq_fetch++;
            prev_low = ext_low;
        end
        prev_addr = addr;
        prev_dout = data_out;
        prev_crd = !crd_n;
    end

    // a hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        t_reset();
        t_timing(2'h0);
        t_timing(2'h3);
        t_indirect();
        t_reset();
        tally_and_finish();
    end
endmodule : mgd_core_bench
`default_nettype wire
